// File: rtl/can_gcs_top.sv
// global enable/standby sequencing and general status of the can controller
// assumes a byte-wide special-register port and a protocol engine that reports its activity
`include "can_gcs_map.svh"
`default_nettype none
module can_gcs_top #(
	parameter int NUM_OBJ = 4
) (
	input  wire logic               MCLK,
	input  wire logic               RST,
	// special register port
	input  wire logic [7:0]         REG_ADDR,
	input  wire logic               REG_WR,
	input  wire logic               REG_RD,
	input  wire logic [7:0]         REG_WDATA,
	output var  logic [7:0]         REG_RDATA,
	// channel enable access
	input  wire logic               CHAN_WR,
	input  wire logic [NUM_OBJ-1:0] CHAN_WDATA,
	output wire logic [NUM_OBJ-1:0] CHAN_RDATA,
	// protocol engine activity
	input  wire logic               ENG_FRAME_ACTIVE,
	input  wire logic               ENG_TX_FRAME,
	input  wire logic               ENG_TX_ACK,
	input  wire logic               ENG_TX_OVERLOAD,
	input  wire logic               ENG_IFS,
	input  wire logic               ENG_TX_PENDING,
	input  wire logic               ENG_RX_ACTIVE,
	input  wire logic               ENG_TX_BIT,
	input  wire logic [NUM_OBJ-1:0] ENG_OBJ_DONE,
	input  wire logic [8:0]         TEC,
	input  wire logic [7:0]         REC,
	// engine control
	output var  logic               ENG_CLK_EN,
	output var  logic               ENG_RUN,
	output var  logic               ENG_SOFT_RESET,
	output wire logic               ENG_RX_ENABLE,
	output var  logic               RX_DATA,
	// bus pins
	input  wire logic               CAN_RX_PIN,
	output var  logic               CAN_TX_PIN,
	output var  logic               TEST_MODE,
	output var  logic               LISTEN_MODE
);
	// elaboration guard: the channel bits must fit one byte-wide register word
	if (NUM_OBJ < 1 || NUM_OBJ > 8) begin
		$error("NUM_OBJ must be 1..8");
	end

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [7:0]                  ctrl_r;
	can_gcs_pkg::power_state_e   pstate_r;
	can_gcs_pkg::power_state_e   pstate_nxt;
	logic [1:0]                  start_cnt_r;
	logic                        enabled_state_flag_r;
	logic                        soft_rst_pend_r;
	logic                        bus_off_flag_r;
	logic                        error_passive_flag_r;
	logic                        transmitter_busy_flag_r;
	logic                        receiver_busy_flag_r;
	logic                        overload_frame_active_r;
	logic                        rx_sync;
	logic                        running;
	logic                        enable_cmd;
	logic [7:0]                  status_word;

	// decode helper for the register port
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a, input logic strobe);
		hit = strobe && (a == ref_a);
	endfunction

	assign enable_cmd = ctrl_r[`GCS_BIT_ENA];
	assign running    = (pstate_r == can_gcs_pkg::ST_RUN) || (pstate_r == can_gcs_pkg::ST_DRAINING);

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	// writable in every power state; soft reset bit reads back zero
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			ctrl_r <= `GCS_CTRL_RESET;
		else if (hit(REG_ADDR, `GCS_ADDR_CONTROL, REG_WR)) begin
			ctrl_r <= REG_WDATA;
			ctrl_r[`GCS_BIT_SRST] <= 1'b0;
		end
	end

	// soft reset: one-cycle pulse to the engine, bit never stays set
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			soft_rst_pend_r <= 1'b0;
		else
			soft_rst_pend_r <= hit(REG_ADDR, `GCS_ADDR_CONTROL, REG_WR) && REG_WDATA[`GCS_BIT_SRST];
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			ENG_SOFT_RESET <= 1'b0;
		else
			ENG_SOFT_RESET <= soft_rst_pend_r;
	end

	// mode bits passed through as levels
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			TEST_MODE   <= 1'b0;
			LISTEN_MODE <= 1'b0;
		end else begin
			TEST_MODE   <= ctrl_r[`GCS_BIT_TEST];
			LISTEN_MODE <= ctrl_r[`GCS_BIT_AUTOBAUD];
		end
	end

	// ------------------------------------------------------------
	// power sequencing
	// ------------------------------------------------------------
	// next state; draining waits for the frame on the bus to end
	always_comb begin
		pstate_nxt = pstate_r;
		unique case (pstate_r)
			can_gcs_pkg::ST_OFF: begin
				if (enable_cmd)
					pstate_nxt = can_gcs_pkg::ST_STARTING;
			end
			can_gcs_pkg::ST_STARTING: begin
				if (!enable_cmd)
					pstate_nxt = can_gcs_pkg::ST_OFF;
				else if (start_cnt_r == 2'(`GCS_START_CYCLES - 1))
					pstate_nxt = can_gcs_pkg::ST_RUN;
			end
			can_gcs_pkg::ST_RUN: begin
				if (!enable_cmd)
					pstate_nxt = can_gcs_pkg::ST_DRAINING;
			end
			can_gcs_pkg::ST_DRAINING: begin
				if (enable_cmd)
					pstate_nxt = can_gcs_pkg::ST_RUN;
				else if (!ENG_FRAME_ACTIVE)
					pstate_nxt = can_gcs_pkg::ST_OFF;
			end
			default: pstate_nxt = can_gcs_pkg::ST_OFF;
		endcase
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			pstate_r <= can_gcs_pkg::ST_OFF;
		else if (ENG_SOFT_RESET)
			pstate_r <= can_gcs_pkg::ST_OFF;
		else
			pstate_r <= pstate_nxt;
	end

	// start-up delay counter, cleared outside the starting state
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			start_cnt_r <= 2'h0;
		else if (pstate_r == can_gcs_pkg::ST_STARTING)
			start_cnt_r <= start_cnt_r + 2'h1;
		else
			start_cnt_r <= 2'h0;
	end

	// clock gate request; ungated from the first start cycle
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			ENG_CLK_EN <= 1'b0;
		else if (ENG_SOFT_RESET)
			ENG_CLK_EN <= 1'b0;
		else
			ENG_CLK_EN <= (pstate_nxt != can_gcs_pkg::ST_OFF);
	end

	// engine run level; held low freezes the engine state
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			ENG_RUN <= 1'b0;
		else if (ENG_SOFT_RESET)
			ENG_RUN <= 1'b0;                                 // state is forced off on this edge
		else
			ENG_RUN <= (pstate_nxt == can_gcs_pkg::ST_RUN) ||
			           (pstate_nxt == can_gcs_pkg::ST_DRAINING);
	end

	// true state lags the command by the start delay or the frame drain
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			enabled_state_flag_r <= 1'b0;
		else
			enabled_state_flag_r <= running;
	end

	// ------------------------------------------------------------
	// bus pins
	// ------------------------------------------------------------
	can_gcs_sync #(
		.RESET_LEVEL(1'b1)
	) u_rx_sync (
		.clk (MCLK),
		.rst (RST),
		.din (CAN_RX_PIN),
		.dout(rx_sync)
	);

	// receiver gated off in standby: engine sees recessive
	assign ENG_RX_ENABLE = running;

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			RX_DATA <= 1'b1;
		else
			RX_DATA <= running ? rx_sync : 1'b1;
	end

	// registered so the pin never glitches on a state change
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			CAN_TX_PIN <= 1'b1;
		else
			CAN_TX_PIN <= running ? ENG_TX_BIT : 1'b1;
	end

	// ------------------------------------------------------------
	// channel enables
	// ------------------------------------------------------------
	// held whenever the engine is not running, so standby keeps them
	can_gcs_chan_mem #(
		.NUM_OBJ(NUM_OBJ)
	) u_chan (
		.clk     (MCLK),
		.rst     (RST),
		.wr_en   (CHAN_WR),
		.wr_data (CHAN_WDATA),
		.hold    (!running),
		.done_clr(ENG_OBJ_DONE),
		.rd_data (CHAN_RDATA)
	);

	// ------------------------------------------------------------
	// activity flags
	// ------------------------------------------------------------
	// hardware levels only; none of them reaches an interrupt
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			transmitter_busy_flag_r <= 1'b0;
			receiver_busy_flag_r    <= 1'b0;
			overload_frame_active_r <= 1'b0;
		end else begin
			transmitter_busy_flag_r <= running && (ENG_TX_FRAME || ENG_TX_ACK || ENG_TX_OVERLOAD ||
			                           (ENG_IFS && ENG_TX_PENDING));
			receiver_busy_flag_r    <= running && ENG_RX_ACTIVE;
			overload_frame_active_r <= running && ENG_TX_OVERLOAD;
		end
	end

	// fault confinement from the counters; kept through standby
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			bus_off_flag_r       <= 1'b0;
			error_passive_flag_r <= 1'b0;
		end else begin
			bus_off_flag_r       <= (TEC >= `GCS_TEC_BUSOFF);
			error_passive_flag_r <= (TEC < `GCS_TEC_BUSOFF) &&
			                        ((TEC >= `GCS_TEC_PASSIVE) ||
			                         ({1'b0, REC} >= `GCS_REC_PASSIVE));
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	// reserved bits read as zero, which is one legal indeterminate value
	always_comb begin
		status_word                    = 8'h00;
		status_word[`GCS_ST_OVERLOAD_FRAME_ACTIVE]      = overload_frame_active_r;
		status_word[`GCS_ST_TRANSMITTER_BUSY_FLAG]      = transmitter_busy_flag_r;
		status_word[`GCS_ST_RECEIVER_BUSY_FLAG]      = receiver_busy_flag_r;
		status_word[`GCS_ST_ENABLED_STATE_FLAG]      = enabled_state_flag_r;
		status_word[`GCS_ST_BUS_OFF_FLAG]      = bus_off_flag_r;
		status_word[`GCS_ST_ERROR_PASSIVE_FLAG]      = error_passive_flag_r;
	end

	// registered read data; unmapped addresses read zero
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			REG_RDATA <= 8'h00;
		else if (hit(REG_ADDR, `GCS_ADDR_STATUS, REG_RD))
			REG_RDATA <= status_word;
		else if (hit(REG_ADDR, `GCS_ADDR_CONTROL, REG_RD))
			REG_RDATA <= ctrl_r;
		else if (REG_RD)
			REG_RDATA <= 8'h00;
	end
endmodule
`default_nettype wire

// File: shared/can_gcs_map.svh
// register map, field positions and timing counts for the global control/status block
// assumes inclusion by the block's design files only
// ------------------------------------------------------------
// ------------------------------------------------------------
`ifndef CAN_GCS_MAP_SVH
`define CAN_GCS_MAP_SVH
`define GCS_ADDR_STATUS   8'hAA
`define GCS_ADDR_CONTROL  8'hAB
`define GCS_CTRL_RESET    8'h00
`define GCS_BIT_SRST      0
`define GCS_BIT_ENA       1
`define GCS_BIT_TEST      2
`define GCS_BIT_AUTOBAUD  3
`define GCS_ST_ERROR_PASSIVE_FLAG       0
`define GCS_ST_BUS_OFF_FLAG       1
`define GCS_ST_ENABLED_STATE_FLAG       2
`define GCS_ST_RECEIVER_BUSY_FLAG       3
`define GCS_ST_TRANSMITTER_BUSY_FLAG       4
`define GCS_ST_OVERLOAD_FRAME_ACTIVE       6
`define GCS_START_CYCLES  2
`define GCS_TEC_PASSIVE   9'd128
`define GCS_REC_PASSIVE   9'd128
`define GCS_TEC_BUSOFF    9'd256
`endif

// File: shared/can_gcs_pkg.sv
// types shared by the global control/status block
// assumes the map header supplies all numeric constants
`default_nettype none
package can_gcs_pkg;
	// power sequencing states of the controller
	typedef enum logic [3:0] {
		ST_OFF      = 4'b0001,
		ST_STARTING = 4'b0010,
		ST_RUN      = 4'b0100,
		ST_DRAINING = 4'b1000
	} power_state_e;
endpackage
`default_nettype wire

// File: rtl/can_gcs_sync.sv
// three-stage synchroniser for one pin level
// assumes a single clock; output changes when stages two and three agree
`default_nettype none
module can_gcs_sync #(
	parameter logic RESET_LEVEL = 1'b1
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic din,
	output var  logic dout
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	// ------------------------------------------------------------
	// capture chain
	// ------------------------------------------------------------
	// first stage feeds only the second, to keep metastability contained
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_r <= RESET_LEVEL;
			s2_r <= RESET_LEVEL;
			s3_r <= RESET_LEVEL;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// accept a change only once two stages agree
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			dout <= RESET_LEVEL;
		else if (s2_r == s3_r)
			dout <= s3_r;
	end
endmodule
`default_nettype wire

// File: rtl/can_gcs_chan_mem.sv
// small memory of per-object channel enable bits
// assumes one write port from the cpu and one clear port from the engine
`default_nettype none
module can_gcs_chan_mem #(
	parameter int NUM_OBJ = 4
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               wr_en,
	input  wire logic [NUM_OBJ-1:0] wr_data,
	input  wire logic               hold,
	input  wire logic [NUM_OBJ-1:0] done_clr,
	output var  logic [NUM_OBJ-1:0] rd_data
);
	// elaboration guard: the enables are read back through a byte-wide port
	if (NUM_OBJ < 1 || NUM_OBJ > 8) begin
		$error("NUM_OBJ must be 1..8");
	end

	logic [NUM_OBJ-1:0] en_r;

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	// cpu writes at any time; engine clears only while running
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			en_r <= '0;
		else if (wr_en)
			en_r <= wr_data;
		else if (!hold)
			en_r <= en_r & ~done_clr;
	end

	// registered read data
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rd_data <= '0;
		else
			rd_data <= en_r;
	end
endmodule
`default_nettype wire

// File: tb/can_gcs_chk_sva.sv
// concurrent checks on the global control/status block ports
// assumes binding into can_gcs_top; sees its ports only
`default_nettype none
module can_gcs_chk #(
	parameter int NUM_OBJ = 4
) (
	input wire logic               MCLK,
	input wire logic               RST,
	input wire logic [7:0]         REG_ADDR,
	input wire logic               REG_WR,
	input wire logic               REG_RD,
	input wire logic [7:0]         REG_WDATA,
	input wire logic [7:0]         REG_RDATA,
	input wire logic               CHAN_WR,
	input wire logic [NUM_OBJ-1:0] CHAN_RDATA,
	input wire logic               ENG_CLK_EN,
	input wire logic               ENG_RUN,
	input wire logic               ENG_RX_ENABLE,
	input wire logic               ENG_SOFT_RESET,
	input wire logic               CAN_TX_PIN
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	// ----
	// properties
	// ----
	// status read request, used to find the answer one cycle later
	wire logic st_rd = REG_RD && REG_ADDR == 8'hAA;
	// two cycles of standby: the pin is registered so the first cycle may still show the frame
	chk_tx_recessive: assert property (!$past(ENG_RX_ENABLE) && !$past(ENG_RX_ENABLE, 2) |-> CAN_TX_PIN)
		else $error("transmit pin not recessive in standby");
	chk_run_gated: assert property (ENG_RUN |-> ENG_CLK_EN)
		else $error("engine runs with clock gated");
	chk_start_delay: assert property ($rose(ENG_RUN) |-> $past(ENG_CLK_EN, 2))
		else $error("engine started too soon");
	chk_enabled_state_flag_lag: assert property (st_rd && $past(ENG_RUN) == ENG_RUN && $past(ENG_RUN, 2) == ENG_RUN
		|=> REG_RDATA[2] == $past(ENG_RUN))
		else $error("enabled flag differs from engine state");
	chk_resv_zero: assert property ($past(st_rd) |-> REG_RDATA[7] == 1'b0 && REG_RDATA[5] == 1'b0)
		else $error("reserved status bits set");
	chk_busy_idle: assert property (st_rd && !ENG_RX_ENABLE && !$past(ENG_RX_ENABLE) && !$past(ENG_RX_ENABLE, 2)
		|=> REG_RDATA[6] == 1'b0 && REG_RDATA[4:3] == 2'b00)
		else $error("busy flags set in standby");
	chk_soft_pulse: assert property (REG_WR && REG_ADDR == 8'hAB && REG_WDATA[0] |-> ##[1:3] ENG_SOFT_RESET)
		else $error("soft reset not issued");
	chk_chan_frozen: assert property (!ENG_RX_ENABLE && !$past(ENG_RX_ENABLE) && !$past(ENG_RX_ENABLE, 2)
		&& !$past(ENG_RX_ENABLE, 3) && !$past(CHAN_WR) && !$past(CHAN_WR, 2) |-> $stable(CHAN_RDATA))
		else $error("channel enables changed in standby");
endmodule
bind can_gcs_top can_gcs_chk #(.NUM_OBJ(NUM_OBJ)) u_can_gcs_chk (.MCLK, .RST, .REG_ADDR, .REG_WR, .REG_RD,
	.REG_WDATA, .REG_RDATA, .CHAN_WR, .CHAN_RDATA, .ENG_CLK_EN, .ENG_RUN, .ENG_RX_ENABLE, .ENG_SOFT_RESET,
	.CAN_TX_PIN);
`default_nettype wire

// File: tb/can_bus_model.sv
// wired-and bus seen through a transceiver, with one remote node
// assumes dominant is 0 and the bench sets the remote drive
`default_nettype none
module can_bus_model #(
	parameter int LOOP_NS = 13
) (
	input  wire logic tx_pin,
	input  wire logic node_dom,
	output wire logic rx_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// dominant wins; keep the loop delay off a clock multiple so the pin never moves on an edge
	assign #(LOOP_NS) rx_pin = tx_pin & ~node_dom;
endmodule
`default_nettype wire

// File: tb/test_can_gcs_top.sv
// self-checking bench for the global control/status block
// assumes the checker binds itself and the bus model loops the pins
`default_nettype none
module test_can_gcs_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, chan_wr = 1'b0;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, rec = 8'h00, rdata;
	logic [3:0]  chan_wdata = 4'h0, obj_done = 4'h0, chan_rdata;
	logic        frm = 1'b0, txf = 1'b0, txa = 1'b0, txo = 1'b0, ifs = 1'b0, pend = 1'b0, rxa = 1'b0;
	logic        txb = 1'b1, node_dom = 1'b0, clk_en, run, srst, rx_en, rx_data, tx_pin, rx_pin, tmode, lmode;
	logic [8:0]  tec = 9'h000;
	logic [31:0] lfsr = 32'h31A77613;
	logic [15:0] expq[$];
	int          failures = 0, cmp_count = 0, cycles = 0;
	can_gcs_top u_can_gcs_top (.MCLK(mclk), .RST(rst), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
		.REG_WDATA(wdata), .REG_RDATA(rdata), .CHAN_WR(chan_wr), .CHAN_WDATA(chan_wdata), .CHAN_RDATA(chan_rdata),
		.ENG_FRAME_ACTIVE(frm), .ENG_TX_FRAME(txf), .ENG_TX_ACK(txa), .ENG_TX_OVERLOAD(txo), .ENG_IFS(ifs),
		.ENG_TX_PENDING(pend), .ENG_RX_ACTIVE(rxa), .ENG_TX_BIT(txb), .ENG_OBJ_DONE(obj_done), .TEC(tec), .REC(rec),
		.ENG_CLK_EN(clk_en), .ENG_RUN(run), .ENG_SOFT_RESET(srst), .ENG_RX_ENABLE(rx_en), .RX_DATA(rx_data),
		.CAN_RX_PIN(rx_pin), .CAN_TX_PIN(tx_pin), .TEST_MODE(tmode), .LISTEN_MODE(lmode));
	can_bus_model u_can_bus_model (.tx_pin(tx_pin), .node_dom(node_dom), .rx_pin(rx_pin));
	// ----
	// helpers
	// ----
	always #5 mclk = ~mclk;
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic give_verdict();
		if (failures == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic fail(input string msg);
		failures++;
		$display("BAD %0t %s", $time, msg);
	endtask
	task automatic cmp_bit(input logic got, input logic exp, input string msg);
		cmp_count++;
		if (got !== exp)
			fail(msg);
	endtask
	task automatic cmp_reg(input logic [7:0] got, input logic [15:0] e);
		cmp_count++;
		if ((got & e[15:8]) !== (e[7:0] & e[15:8]))
			fail("register read mismatch");
	endtask
	// bus tasks start just after an edge, hold the strobe through one sampling edge,
	// then let one edge pass so back-to-back calls never retoggle a strobe in one step
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
		tick(1);
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
		expq.push_back({m, v});
		addr = a;
		rd = 1'b1;
		tick(1);
		rd = 1'b0;
		tick(1);
	endtask
	// read data lands one cycle after the strobe; oldest note is the match
	always @(posedge mclk) begin
		if (rd_d)
			cmp_reg(rdata, expq.pop_front());
		rd_d <= rd;
		cycles++;
		if (cycles == 3000) begin
			fail("timeout");
			give_verdict();
		end
	end
	// ----
	// scenarios
	// ----
	initial begin
		int n;
		logic [7:0] ev;
		tick(10);
		rst = 1'b0;
		rd_reg(8'hAB, 8'hFF, 8'h00);
		rd_reg(8'hAA, 8'h5F, 8'h00);
		rd_reg(8'h10, 8'hFF, 8'h00);
		cmp_bit(tx_pin, 1'b1, "tx active after reset");
		// channel enables written and engine clears ignored while off
		chan_wdata = 4'hA;
		chan_wr = 1'b1;
		tick(1);
		chan_wr = 1'b0;
		tick(2);
		cmp_bit(chan_rdata === 4'hA, 1'b1, "channel write lost");
		obj_done = 4'hF;
		tick(1);
		obj_done = 4'h0;
		tick(2);
		cmp_bit(chan_rdata === 4'hA, 1'b1, "channel cleared while off");
		// enable and time the start
		wr_reg(8'hAB, 8'h02);
		n = 0;
		while (run !== 1'b1 && n < 20) begin
			tick(1);
			n++;
		end
		cmp_bit(n >= 2 && n <= 4, 1'b1, "start delay wrong");
		cmp_bit(clk_en, 1'b1, "clock still gated");
		tick(1);
		rd_reg(8'hAA, 8'h04, 8'h04);
		// random engine activity and error counts
		for (int i = 0; i < 10; i++) begin
			lfsr = next_rand(lfsr);
			{txf, txa, txo, ifs, pend, rxa} = lfsr[5:0];
			tec = lfsr[16:8];
			rec = lfsr[24:17];
			tick(2);
			ev = {1'b0, txo, 1'b0, txf | txa | txo | (ifs & pend), rxa, 1'b1, tec[8], ~tec[8] & (tec[7] | rec[7])};
			rd_reg(8'hAA, 8'h5F, ev);
		end
		{txf, txa, txo, ifs, pend, rxa} = 6'h00;
		tec = 9'h000;
		rec = 8'h00;
		// pins while running
		txb = 1'b0;
		tick(2);
		cmp_bit(tx_pin, 1'b0, "tx pin ignores engine");
		txb = 1'b1;
		node_dom = 1'b1;
		tick(6);
		cmp_bit(rx_data, 1'b0, "receive path dead");
		// disable during a frame: it must finish first
		{frm, txf, txo, rxa} = 4'hF;
		wr_reg(8'hAB, 8'h00);
		tick(6);
		cmp_bit(run, 1'b1, "frame cut short");
		rd_reg(8'hAA, 8'h04, 8'h04);
		frm = 1'b0;
		txb = 1'b0;
		tick(4);
		cmp_bit(run | clk_en | rx_en, 1'b0, "engine not stopped");
		cmp_bit(rx_data, 1'b1, "receiver active in standby");
		cmp_bit(tx_pin, 1'b1, "tx dominant in standby");
		rd_reg(8'hAA, 8'h5C, 8'h00);
		// soft reset while running
		{txf, txo, rxa, node_dom, txb} = 5'h01;
		wr_reg(8'hAB, 8'h02);
		tick(6);
		wr_reg(8'hAB, 8'h03);
		n = 0;
		while (srst !== 1'b1 && n < 5) begin
			tick(1);
			n++;
		end
		cmp_bit(srst, 1'b1, "no soft reset pulse");
		tick(1);
		cmp_bit(srst, 1'b0, "soft reset stuck");
		rd_reg(8'hAB, 8'h03, 8'h02);
		// mode bits are plain registered copies of the control word
		wr_reg(8'hAB, 8'h0E);
		cmp_bit(tmode & lmode, 1'b1, "mode bits not passed");
		tick(3);
		give_verdict();
	end
endmodule
`default_nettype wire
